// ### sfsw_params.svh
/*
 * constants of the upper status word block: field positions, reset values
 * and the expected serial edge count of one frame.
 * assumes: included by the design module by bare name.
 */
//
// Contract
// R01: restart flag reads 0 after reset, write-1 sets
// R02: power summary low while unmasked power fault present
// R03: timebase summary low while unmasked clock fault
// R04: logic summary low while unmasked logic fault
// R05: overcurrent summary low while unmasked overcurrent fault
// R06: checksum error bit reflects previous frame only
// R07: timeout error bit reflects previous frame only
// R08: edge count error bit reflects previous frame
// R09: bad address error bit, per frame
// R10: bad address shows in the following frame
// R11: bits 14..7 reset high; 15..11 writable, 10..7 read-only
// R12: whole word resets to 7FC8h
// R13: bit 2 reports write protect state
// R14: write 0 ignored; summary clears after details
`ifndef SFSW_PARAMS_SVH
`define SFSW_PARAMS_SVH

// bit positions inside the upper status word
`define SFSW_BIT_RESTART   15
`define SFSW_BIT_SUM_HI    14
`define SFSW_BIT_SUM_LO    11
`define SFSW_BIT_ERR_HI    10
`define SFSW_BIT_ERR_LO    7
`define SFSW_BIT_LOCK      2

// reset values
`define SFSW_RST_WORD      16'h7FC8
`define SFSW_RST_RESTART   1'h0
`define SFSW_RST_SUM       4'hF
`define SFSW_RST_ERR       4'hF
`define SFSW_RST_LOW       7'h48

// serial clock edges in one well formed frame
`define SFSW_FRAME_EDGES   8'h20

`endif

// ### sfsw_pkg.sv
/*
 * types of the upper status word block.
 * assumes: sfsw_params.svh is on the include path.
 */
package sfsw_pkg;

   // what the link side gathers during one frame
   typedef struct packed {
      logic       crc_err;   // checksum mismatch seen in this frame
      logic       addr_err;  // register address ffh or above
      logic       wr_req;    // host wrote the status word
      logic [4:0] wr_bits;   // written bits 15..11
      logic [7:0] edges;     // serial clock edges counted
   } sfsw_frame_rec_type;

endpackage

// ### sfsw_status_word.sv
/*
 * upper status word: restart flag, four fault summaries, four per-frame
 * serial error flags and the lower state indications.
 * assumes: serial engine runs on spi_clk_in and marks the first edge of a
 * frame; the serial clock is stopped while frame_sel_n_in is high; the
 * fault groups deliver an "unmasked fault present" level on ref_clk_in.
 */
`timescale 1ns/1ps
`include "sfsw_params.svh"

module sfsw_status_word
   import sfsw_pkg::*;
#(
   parameter logic [7:0] FRAME_EDGES = `SFSW_FRAME_EDGES
)(
   // device clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        sys_rst_in,
   // link side, serial clock domain
   input  wire logic        spi_clk_in,
   input  wire logic        frame_sel_n_in,
   input  wire logic        lnk_first_in,
   input  wire logic        lnk_crc_err_in,
   input  wire logic        lnk_addr_err_in,
   input  wire logic        lnk_wr_in,
   input  wire logic [15:0] lnk_wr_data_in,
   // device side state
   input  wire logic        tmo_err_in,
   input  wire logic [3:0]  fault_any_in,
   input  wire logic [3:0]  cmd_resp_in,
   input  wire logic        lock_state_in,
   input  wire logic        clk_src_in,
   input  wire logic        mode_in,
   // status word
   output logic [15:0]      status_word_out
);

   sfsw_frame_rec_type rec_r;         // link side frame record
   sfsw_frame_rec_type rec_nxt;
   logic [1:0]         sel_sync_r;    // frame select synchroniser
   logic               sel_d_r;       // delayed synchronised select
   logic               tmo_acc_r;     // timeout seen in this frame
   logic               tmo_acc_nxt;
   logic               restart_r;     // bit 15
   logic               restart_nxt;
   logic [3:0]         sum_n_r;       // bits 14..11, active low
   logic [3:0]         sum_n_nxt;
   logic [3:0]         err_n_r;       // bits 10..7, active low
   logic [3:0]         err_n_nxt;
   logic [6:0]         low_r;         // bits 6..0
   logic [6:0]         low_nxt;
   logic               frame_end;     // high in the cycle the synchronised select rose
   logic               frame_start;   // high in the cycle the synchronised select fell
   logic               wr_ok;         // accepted status write

   // link side: the record is rebuilt at each frame's first edge, so it
   // needs no clear from the device clock while the serial clock is stopped
   always_comb begin
      rec_nxt = rec_r;
      if (lnk_first_in) begin
         rec_nxt.crc_err  = lnk_crc_err_in;
         rec_nxt.addr_err = lnk_addr_err_in;
         rec_nxt.wr_req   = lnk_wr_in;
         rec_nxt.wr_bits  = lnk_wr_data_in[15:11];
         rec_nxt.edges    = 8'h01;
      end else begin
         rec_nxt.crc_err  = rec_r.crc_err | lnk_crc_err_in;
         rec_nxt.addr_err = rec_r.addr_err | lnk_addr_err_in;
         if (lnk_wr_in) begin
            rec_nxt.wr_req  = 1'b1;
            rec_nxt.wr_bits = lnk_wr_data_in[15:11];
         end
         // saturate so an overlong frame never wraps back to a legal count
         if (rec_r.edges != 8'hFF) begin
            rec_nxt.edges = rec_r.edges + 8'h01;
         end
      end
   end

   // link side registers
   always_ff @(posedge spi_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rec_r <= '0;
      end else begin
         rec_r <= rec_nxt;
      end
   end

   // select pin: two flops, then an edge detector on the second stage
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sel_sync_r <= 2'h3;
         sel_d_r    <= 1'h1;
      end else begin
         sel_sync_r <= {sel_sync_r[0], frame_sel_n_in};
         sel_d_r    <= sel_sync_r[1];
      end
   end

   // the record is read only after the synchronised select has risen, so
   // the serial clock has stopped and every bit of it is quiet
   assign frame_end   = sel_sync_r[1] & ~sel_d_r;
   assign frame_start = ~sel_sync_r[1] & sel_d_r;
   // a frame with a checksum fault must not alter writable bits
   assign wr_ok       = frame_end & rec_r.wr_req & ~rec_r.crc_err;

   // device side next values
   always_comb begin
      tmo_acc_nxt = tmo_acc_r;
      restart_nxt = restart_r;
      sum_n_nxt   = sum_n_r;
      err_n_nxt   = err_n_r;
      // lower indications follow their sources every cycle
      low_nxt     = {cmd_resp_in, lock_state_in, clk_src_in, mode_in}; // R13
      // timeout gathered across the frame
      if (frame_start) begin
         tmo_acc_nxt = tmo_err_in;
      end else if (tmo_err_in) begin
         tmo_acc_nxt = 1'b1;
      end
      if (frame_end) begin
         // per-frame flags are overwritten, so each frame shows only the
         // faults of the frame before it
         err_n_nxt[3] = ~rec_r.crc_err;                  // R06
         err_n_nxt[2] = ~(tmo_acc_r | tmo_err_in);       // R07
         err_n_nxt[1] = ~(rec_r.edges != FRAME_EDGES);   // R08
         err_n_nxt[0] = ~rec_r.addr_err;                 // R09 R10
      end
      if (wr_ok) begin
         // write 1 restores a bit, write 0 does nothing
         if (rec_r.wr_bits[4]) begin
            restart_nxt = 1'b1;                          // R01 R14
         end
         sum_n_nxt = sum_n_r | rec_r.wr_bits[3:0];       // R14
      end
      // a present fault holds its summary low and wins over a write
      sum_n_nxt = sum_n_nxt & ~fault_any_in;            // R02 R03 R04 R05
   end

   // device side registers
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tmo_acc_r <= 1'h0;
         restart_r <= `SFSW_RST_RESTART;                 // R01
         sum_n_r   <= `SFSW_RST_SUM;                     // R11
         err_n_r   <= `SFSW_RST_ERR;                     // R11
         low_r     <= `SFSW_RST_LOW;                     // R12
      end else begin
         tmo_acc_r <= tmo_acc_nxt;
         restart_r <= restart_nxt;
         sum_n_r   <= sum_n_nxt;
         err_n_r   <= err_n_nxt;
         low_r     <= low_nxt;
      end
   end

   // every bit comes straight from a flop
   assign status_word_out = {restart_r, sum_n_r, err_n_r, low_r}; // R11

   // checks
   // frame_end is high in the very cycle in which the synchronised select
   // is seen risen, so both must be matched in that one cycle
   sequence s_frame_close;
      $rose(sel_sync_r[1]) ##0 frame_end;
   endsequence

   a_reset_word: assert property (@(posedge ref_clk_in)                    // R12
      $fell(sys_rst_in) |-> status_word_out == `SFSW_RST_WORD)
      else $error("status word not at reset value");

   a_restart_hold: assert property (@(posedge ref_clk_in)                  // R01
      disable iff (sys_rst_in) !restart_r && !wr_ok |=> !restart_r)
      else $error("restart flag rose without write");

   a_restart_set: assert property (@(posedge ref_clk_in)                   // R14
      disable iff (sys_rst_in) wr_ok && rec_r.wr_bits[4] |=> restart_r)
      else $error("restart flag not set by write");

   a_fault_low: assert property (@(posedge ref_clk_in)                     // R02
      disable iff (sys_rst_in) fault_any_in[3] |=> !status_word_out[14])
      else $error("power summary high while fault present");

   a_clock_sum: assert property (@(posedge ref_clk_in)                     // R03
      disable iff (sys_rst_in) fault_any_in[2] |=> !status_word_out[13])
      else $error("timebase summary high during fault");

   a_logic_low: assert property (@(posedge ref_clk_in)                     // R04
      disable iff (sys_rst_in) fault_any_in[1] |=> !status_word_out[12])
      else $error("logic summary high during fault");

   a_occ_low: assert property (@(posedge ref_clk_in)                       // R05
      disable iff (sys_rst_in) fault_any_in[0] |=> !status_word_out[11])
      else $error("overcurrent summary high during fault");

   a_power_restore: assert property (@(posedge ref_clk_in)                 // R02
      disable iff (sys_rst_in)
      wr_ok && rec_r.wr_bits[3] && !fault_any_in[3] |=> status_word_out[14])
      else $error("power summary not restored by write");

   a_tmo_report: assert property (@(posedge ref_clk_in)                    // R07
      disable iff (sys_rst_in) frame_end && tmo_acc_r |=> !err_n_r[2])
      else $error("timeout flag not reported");

   a_sum_sticky: assert property (@(posedge ref_clk_in)                    // R04
      disable iff (sys_rst_in)
      !sum_n_r[1] && !(wr_ok && rec_r.wr_bits[1]) |=> !sum_n_r[1])
      else $error("logic summary cleared without write");

   a_occ_sticky: assert property (@(posedge ref_clk_in)                    // R05
      disable iff (sys_rst_in)
      !sum_n_r[0] && !wr_ok |=> $stable(sum_n_r[0]))
      else $error("overcurrent summary changed without write");

   a_crc_report: assert property (@(posedge ref_clk_in)                    // R06
      disable iff (sys_rst_in) frame_end |=> err_n_r[3] == !$past(rec_r.crc_err))
      else $error("checksum flag does not match frame");

   a_err_stable: assert property (@(posedge ref_clk_in)                    // R07
      disable iff (sys_rst_in) !frame_end |=> $stable(err_n_r))
      else $error("per-frame flags moved inside a frame");

   a_edge_count: assert property (@(posedge ref_clk_in)                    // R08
      disable iff (sys_rst_in)
      frame_end && rec_r.edges != FRAME_EDGES |=> !err_n_r[1])
      else $error("edge count fault not reported");

   a_addr_next: assert property (@(posedge ref_clk_in)                     // R10
      disable iff (sys_rst_in) s_frame_close |-> ##1 err_n_r[0] == !$past(rec_r.addr_err))
      else $error("bad address not reported after frame");

   a_lock_bit: assert property (@(posedge ref_clk_in)                      // R13
      disable iff (sys_rst_in)
      1'b1 |=> status_word_out[`SFSW_BIT_LOCK] == $past(lock_state_in))
      else $error("lock bit does not follow state");

endmodule // sfsw_status_word

// ### sfsw_host_model.sv
/*
 * host side model: issues serial frames toward the upper status word.
 * assumes: the bench calls frame() and keeps select high between frames.
 */
`timescale 1ns/1ps

module sfsw_host_model (
   // serial frame signals
   output logic        spi_clk_out,
   output logic        frame_sel_n_out,
   output logic        first_out,
   output logic        crc_err_out,
   output logic        addr_err_out,
   output logic        wr_out,
   output logic [15:0] wr_data_out
);
   // idle: select high, link clock parked low
   initial begin
      spi_clk_out     = 1'h0;
      frame_sel_n_out = 1'h1;
      first_out       = 1'h0;
      crc_err_out     = 1'h0;
      addr_err_out    = 1'h0;
      wr_out          = 1'h0;
      wr_data_out     = 16'h0000;
   end

   // one frame; the clock only runs while select is low
   task automatic frame(input int edges, input logic crc, input logic addr,
                        input logic wr, input logic [15:0] data);
      int k;
      frame_sel_n_out = 1'h0;
      #37;
      crc_err_out  = crc;
      addr_err_out = addr;
      wr_out       = wr;
      wr_data_out  = data;
      for (k = 0; k < edges; k++) begin
         first_out = logic'(k == 0);
         #32 spi_clk_out = 1'h1;
         #32 spi_clk_out = 1'h0;
      end
      first_out    = 1'h0;
      crc_err_out  = 1'h0;
      addr_err_out = 1'h0;
      wr_out       = 1'h0;
      // released data shows the inverse so stale values cannot match
      wr_data_out  = ~data;
      // clock is already stopped before select rises
      #32 frame_sel_n_out = 1'h1;
   endtask
endmodule // sfsw_host_model

// ### sfsw_status_word_tb_top.sv
/*
 * testbench of the upper status word: reset value, lower state bits,
 * restart flag, fault summaries and per-frame serial error flags.
 * assumes: sfsw_host_model plays the host; expectations kept locally.
 */
`timescale 1ns/1ps

module sfsw_status_word_tb_top;
   import sfsw_pkg::*;
   logic        ref_clk_in, sys_rst_in, tmo, lock, clk_src, mode;
   logic        spi_clk, sel_n, first, crc, addr, wr;
   logic [15:0] wdata, status;
   logic [3:0]  fault, cmd, sum_e, err_e;
   logic        restart_e;   // expected bit 15
   int          failures, n_compared, cycles;

   sfsw_host_model host (.spi_clk_out(spi_clk), .frame_sel_n_out(sel_n),
      .first_out(first), .crc_err_out(crc), .addr_err_out(addr),
      .wr_out(wr), .wr_data_out(wdata));

   sfsw_status_word #(.FRAME_EDGES(8'h20)) dut (.ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in), .spi_clk_in(spi_clk), .frame_sel_n_in(sel_n),
      .lnk_first_in(first), .lnk_crc_err_in(crc), .lnk_addr_err_in(addr),
      .lnk_wr_in(wr), .lnk_wr_data_in(wdata), .tmo_err_in(tmo),
      .fault_any_in(fault), .cmd_resp_in(cmd), .lock_state_in(lock),
      .clk_src_in(clk_src), .mode_in(mode), .status_word_out(status));

   // 50 mhz device clock
   initial begin
      ref_clk_in = 1'h0;
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   // hang guard, well above the ~2400 cycles the run needs
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   function automatic logic [15:0] exp_w();
      return {restart_e, sum_e, err_e, cmd, lock, clk_src, mode};
   endfunction

   task automatic chk(input logic [15:0] exp);
      n_compared++;
      if (status !== exp) begin
         failures++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, status);
      end
   endtask

   // frame with optional timeout pulse; mid-frame the word must not move yet
   task automatic run_frame(input int e, input logic c, input logic a,
                            input logic t, input logic [15:0] d);
      fork
         host.frame(e, c, a, 1'h1, d);
         begin
            repeat (5) @(negedge ref_clk_in);
            tmo = t;
            @(negedge ref_clk_in);
            tmo = 1'h0;
            repeat (20) @(negedge ref_clk_in);
            chk(exp_w());
         end
      join
      repeat (8) @(negedge ref_clk_in);
   endtask

   task automatic t_reset;
      sys_rst_in = 1'h1;
      restart_e = 1'h0;
      sum_e = 4'hF;
      err_e = 4'hF;
      repeat (2) @(negedge ref_clk_in);
      chk(16'h7FC8);
      sys_rst_in = 1'h0;
      repeat (2) @(negedge ref_clk_in);
      chk(exp_w());
   endtask

   task automatic t_low_bits;
      {cmd, lock, clk_src, mode} = 7'h2A;
      repeat (2) @(negedge ref_clk_in);
      chk(exp_w());
      {cmd, lock, clk_src, mode} = 7'h55;
      repeat (2) @(negedge ref_clk_in);
      chk(exp_w());
   endtask

   task automatic t_restart;
      run_frame(32, 1'h0, 1'h0, 1'h0, 16'h0000);
      chk(exp_w());
      // a write inside a frame with a checksum fault must not land
      run_frame(32, 1'h1, 1'h0, 1'h0, 16'h8000);
      err_e = 4'h7;
      chk(exp_w());
      run_frame(32, 1'h0, 1'h0, 1'h0, 16'h8000);
      restart_e = 1'h1;
      err_e = 4'hF;
      chk(exp_w());
   endtask

   // each group: fault sets, early clear refused, clear after detail drops
   task automatic t_summary;
      for (int i = 0; i < 4; i++) begin
         fault[i] = 1'h1;
         repeat (2) @(negedge ref_clk_in);
         sum_e[i] = 1'h0;
         chk(exp_w());
         run_frame(32, 1'h0, 1'h0, 1'h0, 16'hF800);
         chk(exp_w());
         fault[i] = 1'h0;
         run_frame(32, 1'h0, 1'h0, 1'h0, 16'hF800);
         sum_e[i] = 1'h1;
         chk(exp_w());
      end
   endtask

   // every serial error kind, each followed by a clean frame
   task automatic t_errors;
      int e [5] = '{32, 32, 31, 33, 32};
      logic [3:0] x [5] = '{4'h7, 4'hB, 4'hD, 4'hD, 4'hE};
      for (int i = 0; i < 5; i++) begin
         run_frame(e[i], logic'(i == 0), logic'(i == 4), logic'(i == 1), 16'h0000);
         err_e = x[i];
         chk(exp_w());
         run_frame(32, 1'h0, 1'h0, 1'h0, 16'h0000);
         err_e = 4'hF;
         chk(exp_w());
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      {tmo, fault, cmd, lock, clk_src, mode} = 12'h048;
      t_reset();
      t_low_bits();
      t_restart();
      t_summary();
      t_errors();
      t_reset();
      end_sim();
   end
endmodule // sfsw_status_word_tb_top
